// File: rtl/ots_pkg.sv
// Shared constants for the over-travel stop sequencer: register map, field
// positions, reset values, modes and state codes.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ots_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_TRQLIM = 8'h08;
  localparam logic [7:0] ADDR_DEVLIM = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ISTAT  = 8'h14;
  localparam logic [7:0] ADDR_ICLR   = 8'h18;
  localparam logic [7:0] ADDR_IEN    = 8'h1c;

  // Field positions
  localparam int CTRL_SETUP_LSB = 0;
  localparam int CTRL_SEQ_LSB   = 2;
  localparam int RELOAD_BIT     = 0;
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_DIR_POS     = 3;
  localparam int ST_DIR_NEG     = 4;
  localparam int ST_SEQ_LSB     = 5;
  localparam int ST_EXCESS      = 7;
  localparam int ST_INHERR      = 8;
  localparam int ST_PEND        = 9;

  // Over-travel inhibit setup values
  localparam logic [1:0] SETUP_DIR = 2'h0;
  localparam logic [1:0] SETUP_OFF = 2'h1;
  localparam logic [1:0] SETUP_ERR = 2'h2;
  localparam logic [1:0] SETUP_RST = SETUP_OFF;

  // Over-travel stop sequence values
  localparam logic [1:0] SEQ_BRAKE   = 2'h0;
  localparam logic [1:0] SEQ_FREE    = 2'h1;
  localparam logic [1:0] SEQ_IMM     = 2'h2;
  localparam logic [1:0] SEQ_ILLEGAL = 2'h3;
  localparam logic [1:0] SEQ_RST     = SEQ_BRAKE;

  // Kind of zero command held after an immediate stop
  localparam logic [1:0] ZK_POS    = 2'h0;
  localparam logic [1:0] ZK_SPD    = 2'h1;
  localparam logic [1:0] ZK_SPDLIM = 2'h2;

  // Interrupt event bits
  localparam int EV_START  = 0;
  localparam int EV_STOP   = 1;
  localparam int EV_EXCESS = 2;
  localparam int EV_INHERR = 3;
  localparam int EV_W      = 4;

  // Speed below which deceleration counts as finished, r/min
  localparam int STOP_SPEED_RPM = 30;

  typedef enum logic [2:0] {
    OTS_IDLE    = 3'b000,
    OTS_DECEL   = 3'b001,
    OTS_STOPPED = 3'b010,
    OTS_ALARM   = 3'b011
  } ots_state_t;

  typedef enum logic [1:0] {
    MODE_POS  = 2'b00,
    MODE_VEL  = 2'b01,
    MODE_TRQ  = 2'b10,
    MODE_FULL = 2'b11
  } ots_mode_t;

endpackage

// File: rtl/ots_seq_if.sv
// Link between the register side and the stop state machine.
// Both ends run on the same clock; no crossing is involved.
`timescale 1ns/10ps
`default_nettype none
interface ots_seq_if;
  logic [1:0]          setup;
  logic [1:0]          seq_act;
  ots_pkg::ots_state_t state;
  logic                dir_pos;
  logic                dir_neg;
  logic                dev_clr;
  logic                inh_err;

  // Register side drives configuration, reads sequencer state
  modport regs (output setup, seq_act,
                input  state, dir_pos, dir_neg, dev_clr, inh_err);
  // Sequencer side
  modport seq  (input  setup, seq_act,
                output state, dir_pos, dir_neg, dev_clr, inh_err);
endinterface
`default_nettype wire

// File: rtl/ots_stop_seq.sv
// Stop state machine: deceleration, hold after stop and alarm takeover.
// Assumes inhibit, error and speed inputs synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module ots_stop_seq #(
  parameter int SPD_W = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Drive inputs
  input  wire logic             positive_travel_inhibit_i,
  input  wire logic             negative_travel_inhibit_i,
  input  wire logic             other_error_i,
  input  wire logic [SPD_W-1:0] motor_speed_i,
  // Register side
  ots_seq_if.seq                sif
);

  typedef struct packed {
    ots_pkg::ots_state_t state;
    logic                dir_pos;
    logic                dir_neg;
    logic                dev_clr;
    logic                inh_err;
  } ots_seq_s_t;

  localparam ots_seq_s_t       S_RST    = '0;
  localparam logic [SPD_W-1:0] STOP_SPD = SPD_W'(ots_pkg::STOP_SPEED_RPM);

  ots_seq_s_t q;
  ots_seq_s_t d;
  logic       inh_any;
  logic       clr_mode;

  assign inh_any  = positive_travel_inhibit_i | negative_travel_inhibit_i;
  assign clr_mode = (sif.seq_act == ots_pkg::SEQ_IMM);

  // Next state; alarms override everything else
  always_comb begin
    d         = q;
    d.dev_clr = 1'b0;
    d.inh_err = (sif.setup == ots_pkg::SETUP_ERR) && inh_any;
    if (other_error_i || d.inh_err) begin
      d.state = ots_pkg::OTS_ALARM;
    end else begin
      unique case (q.state)
        ots_pkg::OTS_IDLE: begin
          if ((sif.setup == ots_pkg::SETUP_DIR) && inh_any) begin
            d.state   = ots_pkg::OTS_DECEL;
            d.dir_pos = positive_travel_inhibit_i;
            d.dir_neg = negative_travel_inhibit_i;
            d.dev_clr = clr_mode; // First clear at start
          end
        end
        ots_pkg::OTS_DECEL: begin
          d.dir_pos = q.dir_pos | positive_travel_inhibit_i;
          d.dir_neg = q.dir_neg | negative_travel_inhibit_i;
          if (!inh_any || (sif.setup != ots_pkg::SETUP_DIR)) begin
            d.state = ots_pkg::OTS_IDLE;
          end else if (motor_speed_i < STOP_SPD) begin
            d.state   = ots_pkg::OTS_STOPPED;
            d.dev_clr = clr_mode; // Second clear at completion
          end
        end
        ots_pkg::OTS_STOPPED: begin
          // Speed is ignored here on purpose: a bump does not restart decel
          if (!inh_any || (sif.setup != ots_pkg::SETUP_DIR)) begin
            d.state = ots_pkg::OTS_IDLE;
          end
        end
        ots_pkg::OTS_ALARM: begin
          d.state = ots_pkg::OTS_IDLE;
        end
        default: begin
          d.state = ots_pkg::OTS_IDLE;
        end
      endcase
      if (d.state == ots_pkg::OTS_IDLE) begin
        d.dir_pos = 1'b0;
        d.dir_neg = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= S_RST;
    end else begin
      q <= d;
    end
  end

  assign sif.state   = q.state;
  assign sif.dir_pos = q.dir_pos;
  assign sif.dir_neg = q.dir_neg;
  assign sif.dev_clr = q.dev_clr;
  assign sif.inh_err = q.inh_err;

  a_stop_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.state == ots_pkg::OTS_IDLE && sif.setup == ots_pkg::SETUP_DIR && positive_travel_inhibit_i
    && !other_error_i |=> q.state == ots_pkg::OTS_DECEL && q.dir_pos)
    else $error("inhibit did not start deceleration");

  a_decel_end: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.state == ots_pkg::OTS_DECEL && motor_speed_i < STOP_SPD && inh_any && !other_error_i
    && sif.setup == ots_pkg::SETUP_DIR |=> q.state == ots_pkg::OTS_STOPPED)
    else $error("slow motor did not reach stopped state");

  a_stop_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.state == ots_pkg::OTS_STOPPED && inh_any && !other_error_i
    && sif.setup == ots_pkg::SETUP_DIR |=> q.state == ots_pkg::OTS_STOPPED)
    else $error("stopped state left while inhibit held");

  a_alarm_prio: assert property (@(posedge mclk_i) disable iff (rst_i)
    other_error_i |=> q.state == ots_pkg::OTS_ALARM)
    else $error("error did not force alarm sequence");

  a_inhibit_err: assert property (@(posedge mclk_i) disable iff (rst_i)
    sif.setup == ots_pkg::SETUP_ERR && inh_any |=> q.inh_err && q.state == ots_pkg::OTS_ALARM)
    else $error("inhibit in error setup did not raise protection error");

  a_clear_twice: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.dev_clr |-> $past(sif.seq_act) == ots_pkg::SEQ_IMM
    && (q.state == ots_pkg::OTS_DECEL || q.state == ots_pkg::OTS_STOPPED))
    else $error("deviation clear outside immediate-stop start or end");

endmodule
`default_nettype wire

// File: rtl/ots_over_travel_stop.sv
// Over-travel stop sequencer top: AHB-Lite registers, interrupt logic and
// registered drive outputs around the stop state machine.
// Assumes one AHB-Lite master, single word transfers, inputs synchronous.
//
// Notes on behaviour
// - Stop sequence field takes 0, 1 or 2 only; resets to 0.
// - Stop sequence acts only while inhibit setup is 0.
// - 0 brakes, 1 frees torque, 2 stops hard and holds zero command.
// - Sequence 2 clears deviations at deceleration start and at completion.
// - Held zero is position, speed or speed limit by control mode.
// - Commands into the inhibit let deviation grow until excess error.
// - Inhibit setup 2: any inhibit raises protection error and alarm stop.
// - Any other error hands the stop to the alarm sequence.
// - Immediate stop keeps control on with the configured torque limit.
// - Deceleration lasts until speed falls below 30 r/min.
// - Once stopped, the hold stays even if speed rises again.
// - Positive inhibit blocks positive travel, negative blocks negative.
`timescale 1ns/10ps
`default_nettype none
module ots_over_travel_stop #(
  parameter int                 SPD_W       = 16,
  parameter int                 DEV_W       = 32,
  parameter int                 TRQ_W       = 16,
  parameter logic [DEV_W-1:0]   DEV_LIM_RST = '1
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // AHB-Lite slave
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  // Drive inputs
  input  wire logic             positive_travel_inhibit_i,
  input  wire logic             negative_travel_inhibit_i,
  input  wire logic             other_error_i,
  input  wire logic [1:0]       control_mode_i,
  input  wire logic [SPD_W-1:0] motor_speed_i,
  input  wire logic [DEV_W-1:0] deviation_i,
  // Drive outputs
  output logic                  short_circuit_brake_o,
  output logic                  torque_zero_pos_o,
  output logic                  torque_zero_neg_o,
  output logic                  zero_cmd_pos_o,
  output logic                  zero_cmd_neg_o,
  output logic      [1:0]       zero_cmd_kind_o,
  output logic                  immediate_stop_o,
  output logic      [TRQ_W-1:0] immediate_stop_torque_limit_o,
  output logic                  deviation_clear_o,
  output logic                  alarm_stop_sequence_o,
  output logic                  excess_deviation_error_o,
  output logic                  travel_inhibit_protection_error_o,
  output logic                  irq_o
);

  typedef struct packed {
    logic [1:0]              setup;
    logic [1:0]              seq_sh;
    logic [1:0]              seq_act;
    logic                    pend;
    logic [TRQ_W-1:0]        trq_lim;
    logic [DEV_W-1:0]        dev_lim;
    logic [ots_pkg::EV_W-1:0] int_stat;
    logic [ots_pkg::EV_W-1:0] int_en;
    logic                    dp_wr;
    logic                    rd_wait;
    logic [7:0]              dp_addr;
    logic                    hready;
    logic [31:0]             hrdata;
    ots_pkg::ots_state_t     prev_st;
    logic                    brake;
    logic                    tz_pos;
    logic                    tz_neg;
    logic                    zc_pos;
    logic                    zc_neg;
    logic [1:0]              zkind;
    logic                    imm;
    logic                    dclr;
    logic                    alarm;
    logic                    exc;
    logic                    inh;
    logic                    irq;
  } ots_top_s_t;

  ots_top_s_t q;
  ots_top_s_t d;
  ots_seq_if  sif ();

  // Word decode, shared by the read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Zero-command kind from the active control mode
  function automatic logic [1:0] zero_kind(input logic [1:0] mode);
    unique case (ots_pkg::ots_mode_t'(mode))
      ots_pkg::MODE_VEL: zero_kind = ots_pkg::ZK_SPD;
      ots_pkg::MODE_TRQ: zero_kind = ots_pkg::ZK_SPDLIM;
      ots_pkg::MODE_POS,
      ots_pkg::MODE_FULL: zero_kind = ots_pkg::ZK_POS;
    endcase
  endfunction

  ots_stop_seq #(
    .SPD_W (SPD_W)
  ) u_seq (
    .mclk_i                    (mclk_i),
    .rst_i                     (rst_i),
    .positive_travel_inhibit_i (positive_travel_inhibit_i),
    .negative_travel_inhibit_i (negative_travel_inhibit_i),
    .other_error_i             (other_error_i),
    .motor_speed_i             (motor_speed_i),
    .sif                       (sif)
  );

  assign sif.setup   = q.setup;
  assign sif.seq_act = q.seq_act;

  logic                     accept;
  logic                     wr_now;
  logic [1:0]               wr_seq;
  logic [ots_pkg::EV_W-1:0] ev;
  logic [ots_pkg::EV_W-1:0] clr;
  logic                     decel;
  logic                     stopped;

  assign accept  = hsel_i & htrans_i[1] & hready_i;
  assign wr_now  = q.dp_wr;
  assign wr_seq  = hwdata_i[ots_pkg::CTRL_SEQ_LSB +: 2];
  assign decel   = (sif.state == ots_pkg::OTS_DECEL);
  assign stopped = (sif.state == ots_pkg::OTS_STOPPED);

  // Bus, registers, interrupts and output decode in one next-state block
  always_comb begin
    d       = q;
    ev      = '0;
    clr     = '0;
    d.dp_wr = 1'b0;
    // Address phase: writes take no wait; reads take one so the data
    // seen reflect any write finishing in the same cycle
    if (accept) begin
      d.dp_addr = haddr_i[7:0];
      d.dp_wr   = hwrite_i;
      if (!hwrite_i) begin
        d.rd_wait = 1'b1;
        d.hready  = 1'b0;
      end
    end
    if (q.rd_wait) begin
      d.rd_wait = 1'b0;
      d.hready  = 1'b1;
      d.hrdata  = '0;
      if (hit(q.dp_addr, ots_pkg::ADDR_CTRL)) begin
        d.hrdata[ots_pkg::CTRL_SETUP_LSB +: 2] = q.setup;
        d.hrdata[ots_pkg::CTRL_SEQ_LSB +: 2]   = q.seq_sh;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_RELOAD)) begin
        d.hrdata[ots_pkg::RELOAD_BIT] = q.pend;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_TRQLIM)) begin
        d.hrdata[TRQ_W-1:0] = q.trq_lim;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_DEVLIM)) begin
        d.hrdata[DEV_W-1:0] = q.dev_lim;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_STATUS)) begin
        d.hrdata[ots_pkg::ST_STATE_LSB +: 3] = sif.state;
        d.hrdata[ots_pkg::ST_DIR_POS]        = sif.dir_pos;
        d.hrdata[ots_pkg::ST_DIR_NEG]        = sif.dir_neg;
        d.hrdata[ots_pkg::ST_SEQ_LSB +: 2]   = q.seq_act;
        d.hrdata[ots_pkg::ST_EXCESS]         = q.exc;
        d.hrdata[ots_pkg::ST_INHERR]         = q.inh;
        d.hrdata[ots_pkg::ST_PEND]           = q.pend;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_ISTAT)) begin
        d.hrdata[ots_pkg::EV_W-1:0] = q.int_stat;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_IEN)) begin
        d.hrdata[ots_pkg::EV_W-1:0] = q.int_en;
      end
    end

    // Reload: the shadow sequence goes live only while no stop runs
    if (q.pend && (sif.state == ots_pkg::OTS_IDLE)) begin
      d.seq_act = q.seq_sh;
      d.pend    = 1'b0;
    end

    // Data phase of a write; unmapped offsets are ignored
    if (wr_now) begin
      if (hit(q.dp_addr, ots_pkg::ADDR_CTRL)) begin
        d.setup = hwdata_i[ots_pkg::CTRL_SETUP_LSB +: 2];
        if (wr_seq != ots_pkg::SEQ_ILLEGAL) begin
          d.seq_sh = wr_seq;
        end
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_RELOAD) && hwdata_i[ots_pkg::RELOAD_BIT]) begin
        d.pend = 1'b1;
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_TRQLIM)) begin
        d.trq_lim = hwdata_i[TRQ_W-1:0];
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_DEVLIM)) begin
        d.dev_lim = hwdata_i[DEV_W-1:0];
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_ICLR)) begin
        clr = hwdata_i[ots_pkg::EV_W-1:0];
      end
      if (hit(q.dp_addr, ots_pkg::ADDR_IEN)) begin
        d.int_en = hwdata_i[ots_pkg::EV_W-1:0];
      end
    end

    // Drive outputs, registered so every pin comes from a flip-flop
    d.brake  = decel && (q.seq_act == ots_pkg::SEQ_BRAKE);
    d.tz_pos = (decel && (q.seq_act == ots_pkg::SEQ_FREE))
               || (stopped && (q.seq_act != ots_pkg::SEQ_IMM) && sif.dir_pos);
    d.tz_neg = (decel && (q.seq_act == ots_pkg::SEQ_FREE))
               || (stopped && (q.seq_act != ots_pkg::SEQ_IMM) && sif.dir_neg);
    d.imm    = decel && (q.seq_act == ots_pkg::SEQ_IMM);
    d.zc_pos = stopped && (q.seq_act == ots_pkg::SEQ_IMM) && sif.dir_pos;
    d.zc_neg = stopped && (q.seq_act == ots_pkg::SEQ_IMM) && sif.dir_neg;
    d.zkind  = zero_kind(control_mode_i);
    d.dclr   = sif.dev_clr;
    d.alarm  = (sif.state == ots_pkg::OTS_ALARM);
    // Deviation is not limited here; the error is the only guard
    d.exc    = (deviation_i > q.dev_lim);
    d.inh    = sif.inh_err;

    // Sticky events; a new event beats a clear in the same cycle
    ev[ots_pkg::EV_START]  = decel && (q.prev_st != ots_pkg::OTS_DECEL);
    ev[ots_pkg::EV_STOP]   = stopped && (q.prev_st != ots_pkg::OTS_STOPPED);
    ev[ots_pkg::EV_EXCESS] = d.exc && !q.exc;
    ev[ots_pkg::EV_INHERR] = d.inh && !q.inh;
    d.prev_st  = sif.state;
    d.int_stat = (q.int_stat & ~clr) | ev;
    d.irq      = |(d.int_stat & d.int_en);
  end

  // Single state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{setup: ots_pkg::SETUP_RST, seq_sh: ots_pkg::SEQ_RST,
             seq_act: ots_pkg::SEQ_RST, dev_lim: DEV_LIM_RST, hready: 1'b1,
             prev_st: ots_pkg::OTS_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign hrdata_o                          = q.hrdata;
  assign hreadyout_o                       = q.hready;
  assign hresp_o                           = 1'b0;
  assign short_circuit_brake_o             = q.brake;
  assign torque_zero_pos_o                 = q.tz_pos;
  assign torque_zero_neg_o                 = q.tz_neg;
  assign zero_cmd_pos_o                    = q.zc_pos;
  assign zero_cmd_neg_o                    = q.zc_neg;
  assign zero_cmd_kind_o                   = q.zkind;
  assign immediate_stop_o                  = q.imm;
  assign immediate_stop_torque_limit_o     = q.trq_lim;
  assign deviation_clear_o                 = q.dclr;
  assign alarm_stop_sequence_o             = q.alarm;
  assign excess_deviation_error_o          = q.exc;
  assign travel_inhibit_protection_error_o = q.inh;
  assign irq_o                             = q.irq;

  a_seq_legal: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.seq_sh != ots_pkg::SEQ_ILLEGAL && q.seq_act != ots_pkg::SEQ_ILLEGAL)
    else $error("stop sequence holds an illegal value");

  a_reload_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(q.seq_act) |-> $past(sif.state) == ots_pkg::OTS_IDLE && !q.pend)
    else $error("stop sequence changed during a stop");

  a_brake_decel: assert property (@(posedge mclk_i) disable iff (rst_i)
    decel && q.seq_act == ots_pkg::SEQ_BRAKE |=> short_circuit_brake_o && !immediate_stop_o)
    else $error("sequence 0 deceleration without brake");

  a_imm_torque: assert property (@(posedge mclk_i) disable iff (rst_i)
    immediate_stop_o |-> $past(decel) && $past(q.seq_act) == ots_pkg::SEQ_IMM
    && !torque_zero_pos_o && !short_circuit_brake_o)
    else $error("immediate stop outside sequence 2 deceleration");

  a_zero_kind: assert property (@(posedge mclk_i) disable iff (rst_i)
    zero_cmd_pos_o && $past(control_mode_i) == ots_pkg::MODE_TRQ
    |-> zero_cmd_kind_o == ots_pkg::ZK_SPDLIM)
    else $error("torque mode zero command is not a speed limit");

  a_excess_err: assert property (@(posedge mclk_i) disable iff (rst_i)
    deviation_i > q.dev_lim ##1 deviation_i > q.dev_lim |-> excess_deviation_error_o)
    else $error("excess deviation not flagged");

  a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq_o == |(q.int_stat & q.int_en))
    else $error("interrupt output does not follow enabled status");

  a_event_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev != '0 |=> (q.int_stat & $past(ev)) == $past(ev))
    else $error("interrupt event not latched in status");

  a_read_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
    accept && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not take exactly one wait state");

endmodule
`default_nettype wire

// File: bench/ots_host_model.sv
// Host controller and positive limit switch model for the stop sequencer.
// Assumes the bench clock; speed follows a target set by the bench.
`timescale 1ns/10ps
`default_nettype none
module ots_host_model (
  // Clock, reset and bench requests
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        pos_req_i,
  input  wire logic [15:0] spd_tgt_i,
  // Drive side
  input  wire logic        dev_clr_i,
  output logic             positive_travel_inhibit_o,
  output logic [15:0]      motor_speed_o,
  output logic [31:0]      deviation_o
);
  // Normal commands go on for 4 ms after an inhibit so the immediate stop
  // can use its torque limit; only then do they halt
  localparam int CMD_HOLD = 1_000_000;

  int   hold_q;
  logic need_home_q;

  // Speed halves toward a lower target, so braking takes a few cycles
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      positive_travel_inhibit_o <= 1'b0;
      motor_speed_o             <= 16'h0000;
      deviation_o               <= 32'h0000_0000;
      hold_q                    <= 0;
      need_home_q               <= 1'b0;
    end else begin
      positive_travel_inhibit_o <= pos_req_i;
      motor_speed_o <= (motor_speed_o > spd_tgt_i) ? motor_speed_o >> 1 : spd_tgt_i;
      if (!pos_req_i) begin
        hold_q <= 0;
      end else if (hold_q < CMD_HOLD) begin
        hold_q <= hold_q + 1;
      end
      // A deviation clear loses the origin: no moves until a homing return
      if (dev_clr_i) begin
        deviation_o <= 32'h0000_0000;
        need_home_q <= 1'b1;
      end else if (need_home_q) begin
        need_home_q <= pos_req_i;
      end else if (!pos_req_i || hold_q < CMD_HOLD) begin
        deviation_o <= deviation_o + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/ots_over_travel_stop_tb.sv
// Self-checking bench for the over-travel stop sequencer.
// Assumes one AHB-Lite master and the host model on the drive side.
`timescale 1ns/10ps
`default_nettype none
module ots_over_travel_stop_tb;
  logic mclk_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, pos = 1'b0;
  logic neg = 1'b0, err = 1'b0, hrdy, hresp, scb, tzp, tzn, zcp, zcn, imm, dclr;
  logic alarm, exc, inh, irq, pti;
  logic [1:0]  htrans = 2'h0, mode = 2'h0, zk;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dev, rd;
  logic [15:0] spd, tgt = 16'h0000, tlim;
  int n_fail = 0, n_compared = 0, nclr, nimm;
  ots_host_model host (.mclk_i(mclk_i), .rst_i(rst_i), .pos_req_i(pos), .spd_tgt_i(tgt),
    .dev_clr_i(dclr),
    .positive_travel_inhibit_o(pti), .motor_speed_o(spd), .deviation_o(dev));
  ots_over_travel_stop uut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .positive_travel_inhibit_i(pti),
    .negative_travel_inhibit_i(neg), .other_error_i(err), .control_mode_i(mode),
    .motor_speed_i(spd), .deviation_i(dev), .short_circuit_brake_o(scb),
    .torque_zero_pos_o(tzp), .torque_zero_neg_o(tzn), .zero_cmd_pos_o(zcp),
    .zero_cmd_neg_o(zcn), .zero_cmd_kind_o(zk), .immediate_stop_o(imm),
    .immediate_stop_torque_limit_o(tlim), .deviation_clear_o(dclr),
    .alarm_stop_sequence_o(alarm), .excess_deviation_error_o(exc),
    .travel_inhibit_protection_error_o(inh), .irq_o(irq));
  // Free-running 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic stop_test;
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wrdy;
    int n;
    n = 0;
    @(posedge mclk_i);
    while (hrdy !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    if (n >= 50) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    wrdy();
    htrans <= 2'h0; hwdata <= wd;
    wrdy();
    rd = hrdata;
  endtask
  task automatic t_regs;
    bus(0, ots_pkg::ADDR_CTRL, 0); chk(rd, 32'h1);
    bus(0, 8'h40, 0); chk(rd, 32'h0);
    chk(hresp, 1'b0);
    bus(1, ots_pkg::ADDR_CTRL, 32'hc);
    bus(0, ots_pkg::ADDR_CTRL, 0); chk(rd, 32'h0);
    bus(1, ots_pkg::ADDR_CTRL, 32'h8); bus(1, ots_pkg::ADDR_IEN, 32'h3);
    bus(0, ots_pkg::ADDR_STATUS, 0); chk(rd & 32'h60, 32'h0);
    bus(1, ots_pkg::ADDR_RELOAD, 32'h1); bus(0, ots_pkg::ADDR_STATUS, 0);
    chk(rd & 32'h60, 32'h40);
  endtask
  task automatic t_imm;
    tgt <= 16'h03e8; repeat (4) @(posedge mclk_i);
    pos <= 1'b1; tgt <= 16'h0000; nclr = 0; nimm = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk_i);
      nclr += dclr; nimm += imm;
    end
    chk(nclr, 2);
    chk(nimm > 0, 1); chk(scb, 0);
    chk({zcp, zcn}, 2'h2); chk(zk, ots_pkg::ZK_POS); chk(irq, 1);
    @(posedge mclk_i); tgt <= 16'h03e8; mode <= 2'h1;
    repeat (6) @(negedge mclk_i);
    chk(zcp, 1); chk(zk, ots_pkg::ZK_SPD);
    @(posedge mclk_i);
    bus(1, ots_pkg::ADDR_ICLR, 32'hf); @(negedge mclk_i); chk(irq, 0);
    @(posedge mclk_i);
    pos <= 1'b0; tgt <= 16'h0000;
  endtask
  // Sequences 0 and 1: brake or free torque while slowing, then hold
  task automatic t_seq(input logic [1:0] s);
    int nb, nt;
    nb = 0;
    nt = 0;
    bus(1'b1, ots_pkg::ADDR_CTRL, {28'h0, s, 2'h0});
    bus(1'b1, ots_pkg::ADDR_RELOAD, 32'h1);
    tgt <= 16'h03e8;
    repeat (4) @(posedge mclk_i);
    pos <= 1'b1;
    tgt <= 16'h0000;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk_i);
      nb += scb;
      nt += tzn;
    end
    chk(nb > 0, s == ots_pkg::SEQ_BRAKE);
    chk(nt > 0, s == ots_pkg::SEQ_FREE);
    chk({scb, tzp, tzn, zcp, imm, dclr}, 6'h10);
    @(posedge mclk_i);
    pos <= 1'b0;
  endtask
  // Torque limit, excess deviation, ignored inhibit and protection error
  task automatic t_guard;
    bus(1'b1, ots_pkg::ADDR_TRQLIM, 32'h0000_0123);
    bus(1'b1, ots_pkg::ADDR_DEVLIM, 32'h0000_0000);
    bus(1'b1, ots_pkg::ADDR_CTRL, 32'h0000_0001);
    pos <= 1'b1;
    repeat (5) @(negedge mclk_i);
    chk({tlim, exc, scb, tzp, imm, alarm, inh}, {16'h0123, 6'h20});
    @(posedge mclk_i);
    bus(1'b1, ots_pkg::ADDR_CTRL, 32'h0000_0002);
    repeat (5) @(negedge mclk_i);
    chk({inh, alarm, imm, tzp}, 4'hc);
    @(posedge mclk_i);
    pos <= 1'b0;
    bus(1'b1, ots_pkg::ADDR_CTRL, 32'h0000_0000);
    bus(1'b1, ots_pkg::ADDR_DEVLIM, 32'hffff_ffff);
    bus(1'b0, ots_pkg::ADDR_ISTAT, 32'h0000_0000);
    chk(rd & 32'hc, 32'hc);
  endtask
  task automatic t_alarm;
    @(posedge mclk_i); err <= 1'b1;
    repeat (4) @(negedge mclk_i); chk(alarm, 1);
    @(posedge mclk_i); err <= 1'b0;
    repeat (4) @(negedge mclk_i); chk(alarm, 0);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_imm();
    t_seq(ots_pkg::SEQ_BRAKE);
    t_seq(ots_pkg::SEQ_FREE);
    t_guard();
    t_alarm();
    stop_test();
  end
endmodule
`default_nettype wire
